// ### dv/dfs_decim_sync_bench.sv
`timescale 1ns/1ps
// ==========================================================
// Bench: sync restarts and settling counts for eight group setups
// ==========================================================
module dfs_decim_sync_bench;
  import dfs_pkg::*;
  localparam int unsigned TS = 4;
  localparam int NCASE = 8;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic start = 1'b0;
  logic sync_i;
  logic mod_a_i = 1'b0;
  logic mod_b_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic [31:0] rd_q;
  logic conversion_ready_strobe_o;
  logic settled_a_o;
  logic settled_b_o;
  logic [DW-1:0] data_a_o;
  logic [DW-1:0] data_b_o;
  logic mod_fixed = 1'b0;
  logic hung = 1'b0;
  // Constant +1 bits give full scale less one code, constant -1 bits negative full scale
  localparam logic [DW-1:0] FULL_POS = {1'b0, {(DW-1){1'b1}}};
  localparam logic [DW-1:0] FULL_NEG = {1'b1, {(DW-1){1'b0}}};
  int bad_count = 0;
  int total_checks = 0;
  // Setups: single rate div4, div8, mixed groups, pin mode, sinc5
  logic [10:0] cfg_t [NCASE] = '{11'h003, 11'h017, 11'h203, 11'h123, 11'h107, 11'h117,
                                 11'h501, 11'h000};
  int first_t [NCASE] = '{336, 9153, 656, 758, 759, 806, 758, 128};
  int set_a_t [NCASE] = '{8400, 267201, 16784, 8822, 17015, 267302, 8822, 640};
  int set_b_t [NCASE] = '{0, 0, 0, 17014, 8823, 8870, 8822, 0};

  dfs_decim_sync #(.TIME_SHIFT(TS)) dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .sync_i(sync_i), .mod_a_i(mod_a_i), .mod_b_i(mod_b_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .conversion_ready_strobe_o(conversion_ready_strobe_o), .settled_a_o(settled_a_o),
    .settled_b_o(settled_b_o), .data_a_o(data_a_o), .data_b_o(data_b_o));
  dfs_host_model host_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .start_i(start),
    .sync_o(sync_i));

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  // Modulator streams are random unless the fixed-level test holds them
  always @(posedge clk_i) begin
    mod_a_i <= mod_fixed ? 1'b1 : 1'($urandom_range(1));
    mod_b_i <= mod_fixed ? 1'b0 : 1'($urandom_range(1));
  end

  // Edges after sync is driven: two synchroniser flops, the restart edge, the output flop
  function automatic logic [31:0] exp_cyc(input int v);
    return (v == 0) ? 32'h0 : 32'((v >> TS) + 4);
  endfunction

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // One bus access; read data is taken in the cycle after the strobe
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_i <= w;
    rd_i <= r;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    #1 rd_q = rdata_o;
  endtask

  // Returns just after the edge at which sync goes high
  task automatic pulse_sync();
    @(posedge clk_i);
    start <= 1'b1;
    @(posedge clk_i);
    start <= 1'b0;
  endtask

  // Early sync, random gap, then a restart that is timed to the flags
  task automatic run_case(input int i);
    int n;
    int nf;
    int na;
    int nb;
    bus(1'b1, 1'b0, OFS_CTRL, {21'h0, cfg_t[i]});
    pulse_sync();
    repeat ($urandom_range(200, 30)) @(posedge clk_i);
    pulse_sync();
    nf = 0;
    na = 0;
    nb = 0;
    for (n = 1; n < 20000 && (nf == 0 || na == 0 || (set_b_t[i] != 0 && nb == 0)); n++) begin
      @(posedge clk_i);
      #1;
      if (n > 3 && nf == 0 && conversion_ready_strobe_o === 1'b1) nf = n;
      if (n > 3 && na == 0 && settled_a_o === 1'b1) na = n;
      if (n > 3 && nb == 0 && settled_b_o === 1'b1) nb = n;
    end
    if (n >= 20000) begin
      bad_count++;
      hung = 1'b1;
    end
    check("first result", 32'(nf), exp_cyc(first_t[i]));
    check("settled a", 32'(na), exp_cyc(set_a_t[i]));
    check("settled b", 32'(nb), exp_cyc(set_b_t[i]));
    bus(1'b0, 1'b1, OFS_STATUS, 32'h0);
    check("status", {29'h0, rd_q[2:0]}, {29'h0, set_b_t[i] != 0, 2'b11});
  endtask

  initial begin
    int i;
    logic [10:0] c;
    void'($urandom(50));
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    bus(1'b0, 1'b1, OFS_CTRL, 32'h0);
    check("ctrl reset", rd_q, {21'h0, CTRL_RST});
    bus(1'b1, 1'b0, 8'h14, 32'hffffffff);
    bus(1'b0, 1'b1, 8'h14, 32'h0);
    check("unmapped", rd_q, 32'h0);
    // Random legal setups read back unchanged
    for (i = 0; i < 4; i++) begin
      c = {3'($urandom_range(7)), 3'($urandom_range(5)), 3'($urandom_range(5)),
           2'($urandom_range(3))};
      bus(1'b1, 1'b0, OFS_CTRL, {21'h0, c});
      bus(1'b0, 1'b1, OFS_CTRL, 32'h0);
      check("ctrl", rd_q, {21'h0, c});
    end
    // Fixed modulator levels: sinc5 at 32 on both groups settles to opposite full scales
    mod_fixed <= 1'b1;
    bus(1'b1, 1'b0, OFS_CTRL, 32'h100);
    pulse_sync();
    repeat (1200) @(posedge clk_i);
    // Restart lands three edges after the sync task; the read samples 1201 edges on
    bus(1'b0, 1'b1, OFS_COUNT, 32'h0);
    check("count", rd_q, 32'd1198);
    bus(1'b0, 1'b1, OFS_DATA_A, 32'h0);
    check("data a", rd_q, 32'(FULL_POS));
    bus(1'b0, 1'b1, OFS_DATA_B, 32'h0);
    check("data b", rd_q, 32'(FULL_NEG));
    check("data a port", 32'(data_a_o), 32'(FULL_POS));
    check("data b port", 32'(data_b_o), 32'(FULL_NEG));
    mod_fixed <= 1'b0;
    for (i = 0; i < NCASE && !hung; i++) begin
      run_case(i);
    end
    finish_test();
  end
endmodule

// ### dv/dfs_decim_sync_chk.sv
`timescale 1ns/1ps
// ==========================================================
// Port checker for the sync and settling block
// ==========================================================
module dfs_decim_sync_chk
  import dfs_pkg::*;
#(
  parameter int unsigned TIME_SHIFT = 0
) (
  input wire logic                  clk_i,
  input wire logic                  sys_rst_i,
  input wire logic                  sync_i,
  input wire logic [7:0]            addr_i,
  input wire logic                  rd_i,
  input wire logic [31:0]           rdata_o,
  input wire logic                  conversion_ready_strobe_o,
  input wire logic                  settled_a_o,
  input wire logic                  settled_b_o,
  input wire logic [dfs_pkg::DW-1:0] data_a_o
);
  // Shortest first and settled counts of any setting, sinc5 at 32 and divider 4
  localparam int unsigned FIRST_MIN  = (128 >> TIME_SHIFT) + 2;
  localparam int unsigned SETTLE_MIN = (640 >> TIME_SHIFT) + 2;
  logic        sync_prev_q;
  logic [19:0] since_q;

  // Cycles since sync rose; saturates so an old strobe never wraps into range
  always_ff @(posedge clk_i) begin
    sync_prev_q <= sync_i;
    if (sys_rst_i) since_q <= 20'hfffff;
    else if (sync_i && !sync_prev_q) since_q <= 20'h0;
    else if (since_q != 20'hfffff) since_q <= since_q + 20'h1;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_strobe_pulse; conversion_ready_strobe_o |=> !conversion_ready_strobe_o; endproperty
  a_strobe_pulse: assert property (p_strobe_pulse)
    else $error("ready strobe longer than one cycle");
  property p_first_min; conversion_ready_strobe_o && since_q > 20'd2 |-> since_q >= FIRST_MIN;
  endproperty
  a_first_min: assert property (p_first_min)
    else $error("result strobe too soon after sync");
  property p_settle_a_min; $rose(settled_a_o) |-> since_q >= SETTLE_MIN; endproperty
  a_settle_a_min: assert property (p_settle_a_min)
    else $error("group A settled too soon after sync");
  property p_settle_b_min; $rose(settled_b_o) |-> since_q >= SETTLE_MIN; endproperty
  a_settle_b_min: assert property (p_settle_b_min)
    else $error("group B settled too soon after sync");
  property p_settle_clear; $fell(settled_a_o) |-> since_q == 20'd2; endproperty
  a_settle_clear: assert property (p_settle_clear)
    else $error("settled flag dropped away from a sync restart");
  property p_data_hold; $changed(data_a_o) |-> conversion_ready_strobe_o || since_q == 20'd2;
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("group A data moved without strobe or restart");
  property p_rd_idle; !rd_i |=> rdata_o == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data present without a read");
  property p_ctrl_hi; rd_i && addr_i == OFS_CTRL |=> rdata_o[31:11] == 21'h0; endproperty
  a_ctrl_hi: assert property (p_ctrl_hi)
    else $error("control read shows bits above the field");
  property p_status_a;
    rd_i && addr_i == OFS_STATUS ##1 $stable(settled_a_o) |-> rdata_o[1] == settled_a_o;
  endproperty
  a_status_a: assert property (p_status_a)
    else $error("status settled bit differs from flag");

  // Main scenarios reached
  c_first: cover property (conversion_ready_strobe_o && since_q > 20'd2 && since_q < 20'hfffff);
  c_settle_b: cover property ($rose(settled_b_o));
  c_restart: cover property ($fell(settled_a_o));
endmodule

bind dfs_decim_sync dfs_decim_sync_chk #(.TIME_SHIFT(TIME_SHIFT)) chk_u (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .sync_i(sync_i), .addr_i(addr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .conversion_ready_strobe_o(conversion_ready_strobe_o),
  .settled_a_o(settled_a_o), .settled_b_o(settled_b_o), .data_a_o(data_a_o));

// ### dv/dfs_host_model.sv
`timescale 1ns/1ps
// ==========================================================
// Host side: raises sync on request and holds it a few cycles
// ==========================================================
module dfs_host_model #(
  parameter int unsigned HOLD = 4
) (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic start_i,
  output logic      sync_o
);
  logic [3:0] hold_q;

  // Hold outlasts the two-flop synchroniser so the rising edge is never lost
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) hold_q <= 4'h0;
    else if (start_i) hold_q <= 4'(HOLD);
    else if (hold_q != 4'h0) hold_q <= hold_q - 4'h1;
  end
  assign sync_o = (hold_q != 4'h0);
endmodule

// ### src/dfs_decim_sync.sv
`timescale 1ns/1ps
module dfs_decim_sync #(
  parameter int unsigned TIME_SHIFT = 0  // Shortens the first and settled thresholds in simulation, not the result period
) (
  input  wire logic                  clk_i,
  input  wire logic                  sys_rst_i,
  input  wire logic                  sync_i,
  input  wire logic                  mod_a_i,
  input  wire logic                  mod_b_i,
  input  wire logic [7:0]            addr_i,
  input  wire logic [31:0]           wdata_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  output logic      [31:0]           rdata_o,
  output logic                       conversion_ready_strobe_o,
  output logic                       settled_a_o,
  output logic                       settled_b_o,
  output logic      [dfs_pkg::DW-1:0] data_a_o,
  output logic      [dfs_pkg::DW-1:0] data_b_o
);
  import dfs_pkg::*;

  // ==========================================================
  // Helpers
  // ==========================================================
  // Clamp a rate index to the six legal rates
  function automatic logic [2:0] rate_idx(input logic [2:0] raw);
    rate_idx = (raw > DEC_IDX_MAX) ? DEC_IDX_MAX : raw;
  endfunction

  // Sinc5 timing: ODR period scaled, in master-clock periods
  function automatic logic [CW-1:0] odr_clk(input logic [2:0] idx, input logic div8);
    odr_clk = CW'(1) << (L_BASE + DIV4_SHIFT + 32'(idx) + 32'(div8));
  endfunction

  // ==========================================================
  // Control register and decode
  // ==========================================================
  logic [CTRL_W-1:0] ctrl_q;
  logic [2:0]        ia;
  logic [2:0]        ib;
  logic              div8;
  logic              grp_b;
  logic              wb_a;
  logic              wb_b;

  assign ia    = rate_idx(ctrl_q[F_DEC_A +: 3]);
  assign ib    = rate_idx(ctrl_q[F_DEC_B +: 3]);
  assign div8  = ctrl_q[F_DIV8];
  assign grp_b = ctrl_q[F_GRP_B];
  // Wideband choice sets the timing only; its ripple and stop band are not built here
  assign wb_a  = ctrl_q[F_WB_A];
  // Pin mode has one filter for all channels
  assign wb_b  = ctrl_q[F_PIN_MODE] ? ctrl_q[F_WB_A] : ctrl_q[F_WB_B];

  // ==========================================================
  // Input synchronisers
  // ==========================================================
  logic [2:0] sync_q;  // Two sync stages plus an edge history stage
  logic [1:0] mod_a_q;
  logic [1:0] mod_b_q;
  logic       sync_rise;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sync_q  <= 3'h0;
      mod_a_q <= 2'h0;
      mod_b_q <= 2'h0;
    end else begin
      sync_q  <= {sync_q[1:0], sync_i};
      mod_a_q <= {mod_a_q[0], mod_a_i};
      mod_b_q <= {mod_b_q[0], mod_b_i};
    end
  end

  assign sync_rise = sync_q[1] & ~sync_q[2];

  // ==========================================================
  // Modulator rate enable, divider 4 or 8
  // ==========================================================
  logic [2:0] div_cnt_q;
  logic       mod_en;

  assign mod_en = (div_cnt_q == (div8 ? DIV8_LAST : DIV4_LAST));

  // Restarting the divider on sync keeps all groups on one phase
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || sync_rise || mod_en) begin
      div_cnt_q <= 3'h0;
    end else begin
      div_cnt_q <= div_cnt_q + 3'h1;
    end
  end

  // ==========================================================
  // Sinc5 decimators, one per rate group
  // ==========================================================
  logic [1:0]          mod_bit;
  logic [1:0][2:0]     g_idx;

  assign mod_bit = {mod_b_q[1], mod_a_q[1]};
  assign g_idx   = {ib, ia};

  for (genvar g = 0; g < 2; g++) begin : g_sinc
    logic signed [ACC_W-1:0] integ_q [ORDER];
    logic signed [ACC_W-1:0] dly_q   [ORDER];
    logic signed [ACC_W-1:0] comb    [ORDER+1];
    logic        [9:0]       dec_cnt_q;
    logic        [9:0]       dec_last;
    logic                    dec_en;
    logic signed [ACC_W-1:0] top;
    logic signed [ACC_W-1:0] sat;
    logic        [5:0]       shift;
    logic        [DW-1:0]    out_q;

    assign dec_last = 10'((32'd1 << (L_BASE + 32'(g_idx[g]))) - 32'd1);
    assign dec_en   = mod_en && (dec_cnt_q == dec_last);
    // Full scale is R^5; one code below it keeps the result positive
    assign top   = ACC_W'(1) << (ORDER * (L_BASE + 32'(g_idx[g])));
    assign sat   = (comb[ORDER] >= top) ? top - ACC_W'(1) : comb[ORDER];
    assign shift = 6'(ORDER * (L_BASE + 32'(g_idx[g])) + 1 - DW);

    // Comb chain, evaluated once per output sample
    always_comb begin
      comb[0] = integ_q[ORDER-1];
      for (int k = 0; k < ORDER; k++) begin
        comb[k+1] = comb[k] - dly_q[k];
      end
    end

    // Integrators run at the modulator rate, combs at the output rate
    always_ff @(posedge clk_i) begin
      if (sys_rst_i || sync_rise) begin
        for (int k = 0; k < ORDER; k++) begin
          integ_q[k] <= '0;
          dly_q[k]   <= '0;
        end
        dec_cnt_q <= 10'h0;
        out_q     <= '0;
      end else if (mod_en) begin
        integ_q[0] <= integ_q[0] + (mod_bit[g] ? ACC_W'(1) : -ACC_W'(1));
        for (int k = 1; k < ORDER; k++) begin
          integ_q[k] <= integ_q[k] + integ_q[k-1];
        end
        dec_cnt_q <= dec_en ? 10'h0 : dec_cnt_q + 10'h1;
        if (dec_en) begin
          for (int k = 0; k < ORDER; k++) begin
            dly_q[k] <= comb[k];
          end
          out_q <= DW'(sat >>> shift);
        end
      end
    end
  end

  // ==========================================================
  // Settling thresholds
  // ==========================================================
  logic [CW-1:0] wb_first;
  logic [CW-1:0] wb_set_a;
  logic [CW-1:0] wb_set_b;
  logic [CW-1:0] first_thr;
  logic [CW-1:0] set_a_thr;
  logic [CW-1:0] set_b_thr;
  logic          a_at_32;
  logic          b_at_32;
  logic [2:0]    fast_idx;
  logic [CW-1:0] odr_p;

  assign a_at_32  = (ia == 3'h0);
  assign b_at_32  = (ib == 3'h0);
  assign fast_idx = (grp_b && ib < ia) ? ib : ia;
  assign odr_p    = odr_clk(fast_idx, div8);

  // Mixed groups share one first instant; neither at 32 falls back to single-rate values, first at the faster rate
  assign wb_first = !grp_b ? ONE_FIRST[div8][ia] :
                    a_at_32 ? MIX_FIRST_A[div8][0] :
                    b_at_32 ? MIX_FIRST_A[div8][ia] :
                    ONE_FIRST[div8][fast_idx];
  assign wb_set_a = !grp_b ? ONE_SET[div8][ia] :
                    b_at_32 ? MIX_SET_A[div8][ia] :
                    a_at_32 ? MIX_SET_A[div8][0] :
                    ONE_SET[div8][ia];
  assign wb_set_b = !grp_b ? ONE_SET[div8][ia] :
                    a_at_32 ? MIX_SET_A32[div8][ib] :
                    b_at_32 ? MIX_SET_B32[div8][ia] :
                    ONE_SET[div8][ib];

  // Wideband latency covers its long group delay; sinc5 settles in five periods
  assign first_thr = (wb_a ? wb_first : odr_p) >> TIME_SHIFT;
  assign set_a_thr = (wb_a ? wb_set_a
                     : CW'(SINC_SETTLE_MUL) * odr_clk(ia, div8)) >> TIME_SHIFT;
  assign set_b_thr = (wb_b ? wb_set_b
                     : CW'(SINC_SETTLE_MUL) * odr_clk(ib, div8)) >> TIME_SHIFT;

  // ==========================================================
  // Settling counter and ready strobe
  // ==========================================================
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] odr_cnt_q;
  logic          run_q;
  logic          first_q;
  logic          hit_first;
  logic          hit_odr;

  assign hit_first = run_q && !first_q && (cnt_q == first_thr);
  assign hit_odr   = first_q && (odr_cnt_q == odr_p - CW'(1));

  // Counter restarts on the sync edge and then counts whole periods
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end else if (sync_rise) begin
      cnt_q <= '0;
      run_q <= 1'b1;
    end else if (run_q && cnt_q != '1) begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  // After the first result, results follow at the faster group's rate
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || sync_rise) begin
      first_q   <= 1'b0;
      odr_cnt_q <= '0;
    end else if (hit_first) begin
      first_q   <= 1'b1;
      odr_cnt_q <= '0;
    end else if (first_q) begin
      odr_cnt_q <= hit_odr ? '0 : odr_cnt_q + CW'(1);
    end
  end

  // Strobe and captured results
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || sync_rise) begin
      conversion_ready_strobe_o <= 1'b0;
      settled_a_o               <= 1'b0;
      settled_b_o               <= 1'b0;
      data_a_o                  <= '0;
      data_b_o                  <= '0;
    end else begin
      conversion_ready_strobe_o <= hit_first || hit_odr;
      if (run_q && cnt_q == set_a_thr) begin
        settled_a_o <= 1'b1;
      end
      if (run_q && grp_b && cnt_q == set_b_thr) begin
        settled_b_o <= 1'b1;
      end
      if (hit_first || hit_odr) begin
        data_a_o <= g_sinc[0].out_q;
        data_b_o <= g_sinc[1].out_q;
      end
    end
  end

  // ==========================================================
  // Register port
  // ==========================================================
  // Writes take effect at once; the host resyncs afterwards
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ctrl_q <= CTRL_RST;
    end else if (wr_i && addr_i == OFS_CTRL) begin
      ctrl_q <= wdata_i[CTRL_W-1:0];
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !rd_i) begin
      rdata_o <= 32'h0;
    end else begin
      unique case (addr_i)
        OFS_CTRL:   rdata_o <= 32'(ctrl_q);
        OFS_STATUS: rdata_o <= {28'h0, run_q, settled_b_o, settled_a_o, first_q};
        OFS_DATA_A: rdata_o <= 32'(data_a_o);
        OFS_DATA_B: rdata_o <= 32'(data_b_o);
        OFS_COUNT:  rdata_o <= 32'(cnt_q);
        default:    rdata_o <= 32'h0;
      endcase
    end
  end
endmodule

// ### src/dfs_pkg.sv
package dfs_pkg;
  // ==========================================================
  // Widths
  // ==========================================================
  localparam int unsigned DW     = 24;  // Result width
  localparam int unsigned CW     = 20;  // Settling counter width
  localparam int unsigned ACC_W  = 52;  // Sinc5 accumulator width, 5*10+2
  localparam int unsigned ORDER  = 5;   // Sinc order
  localparam int unsigned L_BASE = 5;   // log2 of the lowest decimation, 32
  localparam int unsigned NRATE  = 6;   // Selectable decimation rates

  // ==========================================================
  // Register map and fields
  // ==========================================================
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_DATA_A = 8'h08;
  localparam logic [7:0] OFS_DATA_B = 8'h0c;
  localparam logic [7:0] OFS_COUNT  = 8'h10;
  localparam int unsigned CTRL_W      = 11;
  localparam int unsigned F_WB_A      = 0;   // Group A wideband when set
  localparam int unsigned F_WB_B      = 1;   // Group B wideband when set
  localparam int unsigned F_DEC_A     = 2;   // 3 bits, index 0..5 = 32..1024
  localparam int unsigned F_DEC_B     = 5;   // 3 bits
  localparam int unsigned F_GRP_B     = 8;   // Group B in use
  localparam int unsigned F_DIV8      = 9;   // Divider 8, else 4
  localparam int unsigned F_PIN_MODE  = 10;  // One filter type for all
  localparam logic [CTRL_W-1:0] CTRL_RST = 11'h001;
  localparam logic [2:0] DEC_IDX_MAX = 3'h5;
  localparam logic [2:0] DIV4_LAST  = 3'h3;
  localparam logic [2:0] DIV8_LAST  = 3'h7;
  localparam int unsigned DIV4_SHIFT = 2;
  localparam int unsigned SINC_SETTLE_MUL = 5;  // Sinc5 needs five output periods

  // ==========================================================
  // Wideband settling tables, master-clock periods, [div8][rate]
  // ==========================================================
  typedef logic [CW-1:0] dfs_tbl_type [2][NRATE];
  // Single rate, first result
  localparam dfs_tbl_type ONE_FIRST = '{
    '{20'd336, 20'd620, 20'd1187, 20'd2325, 20'd4601, 20'd9153},
    '{20'd656, 20'd1225, 20'd2359, 20'd4635, 20'd9187, 20'd18291}};
  // Single rate, settled result
  localparam dfs_tbl_type ONE_SET = '{
    '{20'd8400, 20'd16748, 20'd33443, 20'd66837, 20'd133625, 20'd267201},
    '{20'd16784, 20'd33481, 20'd66871, 20'd133659, 20'd267235, 20'd534387}};
  // Mixed, first result, indexed by the group A rate
  localparam dfs_tbl_type MIX_FIRST_A = '{
    '{20'd758, 20'd759, 20'd760, 20'd762, 20'd782, 20'd806},
    '{20'd820, 20'd822, 20'd824, 20'd844, 20'd836, 20'd852}};
  // Mixed, either group at 32: group A settled by A rate
  localparam dfs_tbl_type MIX_SET_A = '{
    '{20'd8822, 20'd17015, 20'd33528, 20'd66938, 20'd133646, 20'd267302},
    '{20'd16948, 20'd33590, 20'd66872, 20'd133708, 20'd267332, 20'd534612}};
  // Mixed, B at 32: group B settled by A rate
  localparam dfs_tbl_type MIX_SET_B32 = '{
    '{20'd8822, 20'd8823, 20'd8824, 20'd8826, 20'd8846, 20'd8870},
    '{20'd16948, 20'd16950, 20'd16952, 20'd16972, 20'd16964, 20'd16980}};
  // Mixed, A at 32: group B settled by B rate
  localparam dfs_tbl_type MIX_SET_A32 = '{
    '{20'd8822, 20'd17014, 20'd33526, 20'd66934, 20'd133622, 20'd267253},
    '{20'd16948, 20'd33588, 20'd66868, 20'd133684, 20'd267316, 20'd534580}};
endpackage
